// ### wbl_map.vh
// Register map, field positions, reset values and timing figures of the work bit evaluator.
// Included by every design file of the block; holds definitions only.
`ifndef WBL_MAP_VH
`define WBL_MAP_VH

// Per work bit register group: base plus bit number times stride
`define WBL_GRP_STRIDE   8'h10
`define WBL_OFF_SEL      8'h00
`define WBL_OFF_CTRL     8'h04
`define WBL_OFF_DLY      8'h08
`define WBL_OFF_STATUS   8'h80
`define WBL_OFF_OUTCFG   8'h84
`define WBL_OFF_INPUTS   8'h88

// Selector word: four 6-bit codes, A lowest
`define WBL_SEL_W        6
`define WBL_SEL_A_LSB    0
`define WBL_SEL_B_LSB    8
`define WBL_SEL_C_LSB    16
`define WBL_SEL_D_LSB    24

// Control word fields
`define WBL_CTRL_OP_LSB  0
`define WBL_CTRL_OP_W    3
`define WBL_CTRL_OINV    4
`define WBL_CTRL_IINV_LSB 8
`define WBL_CTRL_UNIT    12

// Operation type encodings
`define WBL_OP_NONE      3'h0
`define WBL_OP_ANDOR     3'h1
`define WBL_OP_ORAND     3'h2
`define WBL_OP_ANY       3'h3
`define WBL_OP_ALL       3'h4

// Delay word fields: on delay low, off delay high
`define WBL_DLY_W        14
`define WBL_DLY_ON_LSB   0
`define WBL_DLY_OFF_LSB  16
`define WBL_DLY_MAX      14'h270f

// Output configuration bits
`define WBL_OCFG_OUT1_LIN   0
`define WBL_OCFG_OUT2_LIN   1
`define WBL_OCFG_OUT2_NONE  2

// Reset values
`define WBL_RST_WORD     32'h0000_0000

// Timing
`define WBL_CLK_HZ       100000000
`define WBL_SEC_S        1
`define WBL_MIN_SEC      60
`define WBL_EVAL_NS      1000
`define WBL_CLK_NS       10

`endif

// ### wbl_eval.v
// One work bit combination: four selected sources, per-input and output polarity, operation.
// Assumes the source vector is stable for the cycle in which the result is sampled.
`timescale 1ns/10ps
`include "wbl_map.vh"

module wbl_eval (
   src,
   sel_word,
   ctrl_word,
   result
);
   input  wire [63:0] src;
   input  wire [31:0] sel_word;
   input  wire [31:0] ctrl_word;
   output reg         result;

   // Codes past the table pick zero bits of the source vector
   function pick;
      input [63:0] v;
      input [5:0]  code;
      begin
         pick = v[code];
      end
   endfunction

   wire [3:0] raw;
   wire [3:0] cin;
   wire [2:0] op;

   assign raw[0] = pick(src, sel_word[`WBL_SEL_A_LSB +: `WBL_SEL_W]);
   assign raw[1] = pick(src, sel_word[`WBL_SEL_B_LSB +: `WBL_SEL_W]);
   assign raw[2] = pick(src, sel_word[`WBL_SEL_C_LSB +: `WBL_SEL_W]);
   assign raw[3] = pick(src, sel_word[`WBL_SEL_D_LSB +: `WBL_SEL_W]);
   assign cin    = raw ^ ctrl_word[`WBL_CTRL_IINV_LSB +: 4];
   assign op     = ctrl_word[`WBL_CTRL_OP_LSB +: `WBL_CTRL_OP_W];

   always @* begin
      case (op)
         `WBL_OP_ANDOR: result = (cin[0] & cin[1]) | (cin[2] & cin[3]);
         `WBL_OP_ORAND: result = (cin[0] | cin[2]) & (cin[1] | cin[3]);
         `WBL_OP_ANY:   result = |cin;
         `WBL_OP_ALL:   result = &cin;
         default:       result = 1'b0;
      endcase
      // No operation stays off whatever the output polarity
      if (op == `WBL_OP_ANDOR || op == `WBL_OP_ORAND || op == `WBL_OP_ANY ||
          op == `WBL_OP_ALL) begin
         result = result ^ ctrl_word[`WBL_CTRL_OINV];
      end else begin
         result = 1'b0;
      end
   end
endmodule

// ### wbl_delay.v
// On/off delay stage of one work bit, holding the work bit value itself.
// Assumes eval_tick and unit_tick are one-cycle pulses of the same clock.
`timescale 1ns/10ps
`include "wbl_map.vh"

module wbl_delay (
   hclk,
   hresetn,
   eval_tick,
   unit_tick,
   cond,
   on_dly,
   off_dly,
   bit_q
);
   input  wire                   hclk;
   input  wire                   hresetn;
   input  wire                   eval_tick;
   input  wire                   unit_tick;
   input  wire                   cond;
   input  wire [`WBL_DLY_W-1:0]  on_dly;
   input  wire [`WBL_DLY_W-1:0]  off_dly;
   output reg                    bit_q;

   reg  [`WBL_DLY_W-1:0] cnt_q;
   wire [`WBL_DLY_W-1:0] need;
   wire                  differ;
   wire                  expired;

   assign differ  = cond ^ bit_q;
   assign need    = cond ? on_dly : off_dly;
   // Zero disables the delay; the condition is taken at the next evaluation
   assign expired = (need == {`WBL_DLY_W{1'b0}}) || (cnt_q >= need);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bit_q <= 1'b0;
         cnt_q <= {`WBL_DLY_W{1'b0}};
      end else begin
         if (!differ) begin
            // Any return of the condition restarts the wait
            cnt_q <= {`WBL_DLY_W{1'b0}};
         end else if (unit_tick && cnt_q != {`WBL_DLY_W{1'b1}}) begin
            cnt_q <= cnt_q + 1'b1;
         end
         if (eval_tick && differ && expired) begin
            bit_q <= cond;
         end
      end
   end
endmodule

// ### wbl_top.v
// Work bit logic evaluator: eight configurable work bits behind an AHB-Lite register slave.
// Assumes status and event inputs are synchronous to hclk and a single bus master.
//
// What this block does
// - Each work bit has an operation type; none is default and holds it off.
// - Type 1 gives (A and B) or (C and D).
// - Type 2 gives (A or C) and (B or D).
// - Type 3 gives A or B or C or D.
// - Type 4 gives A and B and C and D.
// - Code 0 is false, 1 true, 2 true for the first evaluation only.
// - Codes 3 to 6 are event inputs 1 to 4.
// - Codes 7 to 9 are alarms 1 to 3; 10 is either switching-count alarm.
// - Code 11 is control output 1 state, false when it is a linear output.
// - Code 12 is control output 2 state, false when absent or linear.
// - Code 18 is manual mode, code 19 is reset state.
// - Codes 28 to 31 are time signals, program end and stage flag.
// - Codes 32 to 34 program number, 35 reserved, 36 to 40 segment number.
// - Codes 41 to 48 are work bits; all selectors share the table.
// - Each input A to D may be inverted before combination.
// - Each work bit may present its combined result inverted.
// - Eight independent work bits, available as outputs for routing.
// - Optional on delay of 0 to 9999 units, zero disables it.
// - Optional off delay of 0 to 9999 units, zero disables it.
// - Delay unit is seconds or minutes, seconds by default.
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "wbl_map.vh"

module wbl_top #(
   parameter NBITS       = 8,
   parameter EVAL_CYCLES = `WBL_EVAL_NS / `WBL_CLK_NS,
   parameter SEC_CYCLES  = `WBL_SEC_S * `WBL_CLK_HZ,
   parameter MIN_SECS    = `WBL_MIN_SEC
) (
   hclk,
   hresetn,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hrdata,
   hreadyout,
   hresp,
   event_in,
   alarm_in,
   count_alarm,
   out1_state,
   out2_state,
   sensor_error,
   remote_setpoint_error,
   heater_break_alarm,
   heater_short_alarm,
   heater_overcurrent_alarm,
   manual_mode,
   reset_state,
   status_flags,
   sequencer_flags,
   program_number,
   segment_number,
   work_bits,
   eval_strobe
);
   input  wire        hclk;
   input  wire        hresetn;
   input  wire        hsel;
   input  wire [31:0] haddr;
   input  wire [1:0]  htrans;
   input  wire        hwrite;
   input  wire [2:0]  hsize;
   input  wire [31:0] hwdata;
   input  wire        hready;
   output reg  [31:0] hrdata;
   output wire        hreadyout;
   output wire [1:0]  hresp;
   input  wire [3:0]  event_in;
   input  wire [2:0]  alarm_in;
   input  wire [1:0]  count_alarm;
   input  wire        out1_state;
   input  wire        out2_state;
   input  wire        sensor_error;
   input  wire        remote_setpoint_error;
   input  wire        heater_break_alarm;
   input  wire        heater_short_alarm;
   input  wire        heater_overcurrent_alarm;
   input  wire        manual_mode;
   input  wire        reset_state;
   input  wire [7:0]  status_flags;
   input  wire [3:0]  sequencer_flags;
   input  wire [2:0]  program_number;
   input  wire [4:0]  segment_number;
   output wire [7:0]  work_bits;
   output reg         eval_strobe;

   integer i;

   reg [31:0] sel_q  [0:7];
   reg [31:0] ctrl_q [0:7];
   reg [31:0] dly_q  [0:7];
   reg [2:0]  outcfg_q;

   // Bus pipeline
   reg        wr_q;
   reg [7:0]  waddr_q;
   reg        rd_q;
   reg        rd_rdy_q;
   reg [7:0]  raddr_q;
   wire       accept;

   // Time base
   reg [31:0] eval_cnt_q;
   reg [31:0] sec_cnt_q;
   reg [7:0]  min_cnt_q;
   reg        sec_tick_q;
   reg        min_tick_q;
   reg        first_q;

   wire [63:0] src;
   wire [7:0]  cond;
   wire [7:0]  bits_q;

   // ---------------- AHB-Lite slave ----------------
   // Reads take one wait state so that a read right after a write sees the new value
   assign accept    = hsel & htrans[1] & hready;
   assign hreadyout = ~rd_q | rd_rdy_q;
   assign hresp     = 2'b00;

   function [31:0] reg_read;
      input [7:0] a;
      begin
         reg_read = `WBL_RST_WORD;
         if (a[7] == 1'b0) begin
            case ({4'h0, a[3:0]})
               `WBL_OFF_SEL:  reg_read = sel_q[a[6:4]];
               `WBL_OFF_CTRL: reg_read = ctrl_q[a[6:4]];
               `WBL_OFF_DLY:  reg_read = dly_q[a[6:4]];
               default:       reg_read = `WBL_RST_WORD;
            endcase
         end else begin
            case (a)
               `WBL_OFF_STATUS: reg_read = {24'h000000, bits_q};
               `WBL_OFF_OUTCFG: reg_read = {29'h00000000, outcfg_q};
               `WBL_OFF_INPUTS: reg_read = src[63:32];
               default:         reg_read = `WBL_RST_WORD;
            endcase
         end
      end
   endfunction

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q     <= 1'b0;
         waddr_q  <= 8'h00;
         rd_q     <= 1'b0;
         rd_rdy_q <= 1'b0;
         raddr_q  <= 8'h00;
      end else begin
         wr_q <= 1'b0;
         if (accept && hwrite && hsize == 3'h2 && haddr[31:8] == 24'h000000) begin
            wr_q    <= 1'b1;
            waddr_q <= haddr[7:0];
         end
         if (rd_q && !rd_rdy_q) begin
            rd_rdy_q <= 1'b1;
         end else if (hreadyout) begin
            rd_q     <= 1'b0;
            rd_rdy_q <= 1'b0;
         end
         if (accept && !hwrite) begin
            rd_q     <= 1'b1;
            rd_rdy_q <= 1'b0;
            raddr_q  <= haddr[7:0];
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `WBL_RST_WORD;
      end else if (rd_q && !rd_rdy_q) begin
         if (raddr_q[1:0] == 2'b00) begin
            hrdata <= reg_read(raddr_q);
         end else begin
            hrdata <= `WBL_RST_WORD;
         end
      end
   end

   // Register file; the reset value leaves every work bit at no operation
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < 8; i = i + 1) begin
            sel_q[i]  <= `WBL_RST_WORD;
            ctrl_q[i] <= `WBL_RST_WORD;
            dly_q[i]  <= `WBL_RST_WORD;
         end
         outcfg_q <= 3'h0;
      end else if (wr_q && waddr_q[1:0] == 2'b00) begin
         if (waddr_q[7] == 1'b0) begin
            case ({4'h0, waddr_q[3:0]})
               `WBL_OFF_SEL: begin
                  sel_q[waddr_q[6:4]] <= hwdata & 32'h3f3f_3f3f;
               end
               `WBL_OFF_CTRL: begin
                  ctrl_q[waddr_q[6:4]] <= hwdata & 32'h0000_1f17;
               end
               `WBL_OFF_DLY: begin
                  // Delays beyond the settable range are clipped to it
                  dly_q[waddr_q[6:4]][`WBL_DLY_ON_LSB +: `WBL_DLY_W] <=
                     (hwdata[`WBL_DLY_ON_LSB +: `WBL_DLY_W] > `WBL_DLY_MAX) ?
                     `WBL_DLY_MAX : hwdata[`WBL_DLY_ON_LSB +: `WBL_DLY_W];
                  dly_q[waddr_q[6:4]][`WBL_DLY_OFF_LSB +: `WBL_DLY_W] <=
                     (hwdata[`WBL_DLY_OFF_LSB +: `WBL_DLY_W] > `WBL_DLY_MAX) ?
                     `WBL_DLY_MAX : hwdata[`WBL_DLY_OFF_LSB +: `WBL_DLY_W];
               end
               default: begin
               end
            endcase
         end else if (waddr_q == `WBL_OFF_OUTCFG) begin
            outcfg_q <= hwdata[2:0];
         end
      end
   end

   // ---------------- Time base ----------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eval_cnt_q  <= 32'h0000_0000;
         eval_strobe <= 1'b0;
      end else begin
         eval_strobe <= 1'b0;
         if (eval_cnt_q >= EVAL_CYCLES - 1) begin
            eval_cnt_q  <= 32'h0000_0000;
            eval_strobe <= 1'b1;
         end else begin
            eval_cnt_q <= eval_cnt_q + 32'h0000_0001;
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sec_cnt_q  <= 32'h0000_0000;
         min_cnt_q  <= 8'h00;
         sec_tick_q <= 1'b0;
         min_tick_q <= 1'b0;
      end else begin
         sec_tick_q <= 1'b0;
         min_tick_q <= 1'b0;
         if (sec_cnt_q >= SEC_CYCLES - 1) begin
            sec_cnt_q  <= 32'h0000_0000;
            sec_tick_q <= 1'b1;
            if (min_cnt_q >= MIN_SECS - 1) begin
               min_cnt_q  <= 8'h00;
               min_tick_q <= 1'b1;
            end else begin
               min_cnt_q <= min_cnt_q + 8'h01;
            end
         end else begin
            sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
         end
      end
   end

   // Power-up pulse lasts until the first evaluation has consumed it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_q <= 1'b1;
      end else if (eval_strobe) begin
         first_q <= 1'b0;
      end
   end

   // ---------------- Source table ----------------
   assign src[0]     = 1'b0;
   assign src[1]     = 1'b1;
   assign src[2]     = first_q;
   assign src[6:3]   = event_in;
   assign src[9:7]   = alarm_in;
   assign src[10]    = |count_alarm;
   assign src[11]    = out1_state & ~outcfg_q[`WBL_OCFG_OUT1_LIN];
   assign src[12]    = out2_state & ~outcfg_q[`WBL_OCFG_OUT2_LIN] &
                       ~outcfg_q[`WBL_OCFG_OUT2_NONE];
   assign src[13]    = sensor_error;
   assign src[14]    = remote_setpoint_error;
   assign src[15]    = heater_break_alarm;
   assign src[16]    = heater_short_alarm;
   assign src[17]    = heater_overcurrent_alarm;
   assign src[18]    = manual_mode;
   assign src[19]    = reset_state;
   assign src[27:20] = status_flags;
   assign src[31:28] = sequencer_flags;
   assign src[34:32] = program_number;
   assign src[35]    = 1'b0;
   assign src[40:36] = segment_number;
   assign src[48:41] = bits_q;
   assign src[63:49] = 15'h0000;

   // ---------------- Work bits ----------------
   genvar g;
   generate
      for (g = 0; g < NBITS; g = g + 1) begin : gen_bit
         wbl_eval u_eval (
            .src       (src),
            .sel_word  (sel_q[g]),
            .ctrl_word (ctrl_q[g]),
            .result    (cond[g])
         );
         wbl_delay u_delay (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .eval_tick (eval_strobe),
            .unit_tick (ctrl_q[g][`WBL_CTRL_UNIT] ? min_tick_q : sec_tick_q),
            .cond      (cond[g]),
            .on_dly    (dly_q[g][`WBL_DLY_ON_LSB +: `WBL_DLY_W]),
            .off_dly   (dly_q[g][`WBL_DLY_OFF_LSB +: `WBL_DLY_W]),
            .bit_q     (bits_q[g])
         );
      end
   endgenerate

   assign work_bits = bits_q;
endmodule

// ### wbl_src_model.sv
// Far-side model: controller status and event sources, one bit per selector code.
// Assumes the bench changes src_v right after a rising hclk edge; bit 49 drives count alarm 2.
`timescale 1ns/10ps
module wbl_src_model (
   input  wire [63:0] src_v,
   output wire [3:0]  event_in,
   output wire [2:0]  alarm_in,
   output wire [1:0]  count_alarm,
   output wire        out1_state,
   output wire        out2_state,
   output wire        sensor_error,
   output wire        remote_setpoint_error,
   output wire        heater_break_alarm,
   output wire        heater_short_alarm,
   output wire        heater_overcurrent_alarm,
   output wire        manual_mode,
   output wire        reset_state,
   output wire [7:0]  status_flags,
   output wire [3:0]  sequencer_flags,
   output wire [2:0]  program_number,
   output wire [4:0]  segment_number
);
   assign event_in                 = src_v[6:3];
   assign alarm_in                 = src_v[9:7];
   // Second alarm sits on an unused code so either alarm can be raised alone
   assign count_alarm              = {src_v[49], src_v[10]};
   assign out1_state               = src_v[11];
   assign out2_state               = src_v[12];
   assign sensor_error             = src_v[13];
   assign remote_setpoint_error    = src_v[14];
   assign heater_break_alarm       = src_v[15];
   assign heater_short_alarm       = src_v[16];
   assign heater_overcurrent_alarm = src_v[17];
   assign manual_mode              = src_v[18];
   assign reset_state              = src_v[19];
   assign status_flags             = src_v[27:20];
   assign sequencer_flags          = src_v[31:28];
   assign program_number           = src_v[34:32];
   assign segment_number           = src_v[40:36];
endmodule

// ### wbl_chk.sv
// Port-level checks of the work bit evaluator: bus timing, evaluation pacing, status reads.
// Assumes one bus master and hready tied to hreadyout.
`timescale 1ns/10ps
module wbl_chk #(
   parameter EVAL_CYCLES = 100
) (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire [1:0]  hresp,
   input wire [7:0]  work_bits,
   input wire        eval_strobe
);
   logic [31:0] gap_q;
   logic        wr_seen_q;
   wire rd_go = hsel && htrans[1] && hready && !hwrite;
   wire wr_go = hsel && htrans[1] && hready && hwrite;
   wire bad_a = (haddr[7:0] > 8'h88 || (!haddr[7] && haddr[3:2] == 2'b11))
                && haddr[1:0] == 2'b00 && haddr[31:8] == 24'h0;
   // Restarting at 1 lines up the first gap after reset with the later ones
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_q <= 32'h0;
         wr_seen_q <= 1'b0;
      end else begin
         gap_q <= eval_strobe ? 32'h1 : gap_q + 32'h1;
         wr_seen_q <= wr_seen_q | wr_go;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_okay;
      hresp == 2'b00;
   endproperty
   a_okay: assert property (p_okay) else $error("response not OKAY");
   property p_rd_wait;
      rd_go |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_fast;
      wr_go |=> hreadyout;
   endproperty
   a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
   property p_period;
      eval_strobe == (gap_q == EVAL_CYCLES);
   endproperty
   a_period: assert property (p_period) else $error("evaluation pacing wrong");
   property p_hold;
      !eval_strobe |=> $stable(work_bits);
   endproperty
   a_hold: assert property (p_hold) else $error("work bits moved off evaluation");
   property p_idle;
      !wr_seen_q |-> work_bits == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("work bit set with default setup");
   property p_unmapped;
      rd_go && bad_a |-> ##2 hrdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_status;
      (rd_go && haddr[7:0] == 8'h80 && !eval_strobe) ##1 !eval_strobe
         |=> hrdata == {24'h0, work_bits};
   endproperty
   a_status: assert property (p_status) else $error("status read mismatch");
endmodule

bind wbl_top wbl_chk #(.EVAL_CYCLES(EVAL_CYCLES)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .work_bits(work_bits), .eval_strobe(eval_strobe)
);

// ### tb_top.sv
// Self-checking bench of the work bit evaluator: operations, source codes, registers, delays.
// Assumes short evaluation and time-unit parameters; the bench is the only bus master.
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {
      logic [2:0] op; logic [3:0] inv; logic oinv; logic [3:0] ev; logic exp;
   } wbl_row_t;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = 32'h0;
   logic [63:0] src_v = 64'h0;
   logic [31:0] smp, rd;
   logic [7:0]  ra [0:4];
   wbl_row_t    rows [0:12];
   integer      num_errors = 0;
   integer      total_checks = 0;
   integer      c, i;
   wire [31:0] hrdata;
   wire        hreadyout, eval_strobe, out1_state, out2_state, sensor_error, manual_mode;
   wire        remote_setpoint_error, heater_break_alarm, heater_short_alarm, reset_state;
   wire        heater_overcurrent_alarm;
   wire [1:0]  hresp, count_alarm;
   wire [7:0]  work_bits, status_flags;
   wire [3:0]  event_in, sequencer_flags;
   wire [2:0]  alarm_in, program_number;
   wire [4:0]  segment_number;
   wire        hready = hreadyout;

   always #5 hclk = ~hclk;

   wbl_src_model u_src (.src_v(src_v), .event_in(event_in), .alarm_in(alarm_in),
      .count_alarm(count_alarm), .out1_state(out1_state), .out2_state(out2_state),
      .sensor_error(sensor_error), .remote_setpoint_error(remote_setpoint_error),
      .heater_break_alarm(heater_break_alarm), .heater_short_alarm(heater_short_alarm),
      .heater_overcurrent_alarm(heater_overcurrent_alarm), .manual_mode(manual_mode),
      .reset_state(reset_state), .status_flags(status_flags),
      .sequencer_flags(sequencer_flags), .program_number(program_number),
      .segment_number(segment_number));

   wbl_top #(.EVAL_CYCLES(10), .SEC_CYCLES(20), .MIN_SECS(3)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .event_in(event_in), .alarm_in(alarm_in),
      .count_alarm(count_alarm), .out1_state(out1_state), .out2_state(out2_state),
      .sensor_error(sensor_error), .remote_setpoint_error(remote_setpoint_error),
      .heater_break_alarm(heater_break_alarm), .heater_short_alarm(heater_short_alarm),
      .heater_overcurrent_alarm(heater_overcurrent_alarm), .manual_mode(manual_mode),
      .reset_state(reset_state), .status_flags(status_flags),
      .sequencer_flags(sequencer_flags), .program_number(program_number),
      .segment_number(segment_number), .work_bits(work_bits), .eval_strobe(eval_strobe));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // hreadyout is settled by the falling edge, so this samples it as the rising edge will
   task automatic wt;
      @(negedge hclk);
      while (hreadyout !== 1'b1) @(negedge hclk);
      smp = hrdata;
      @(posedge hclk);
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wt();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wt();
      rd = smp;
   endtask

   task automatic cfg(input int b, input logic [31:0] s, input logic [31:0] ct);
      bus(1'b1, 8'(b * 16), s);
      bus(1'b1, 8'(b * 16 + 4), ct);
   endtask

   task automatic evw(input int k);
      repeat (k) begin
         @(negedge hclk);
         while (eval_strobe !== 1'b1) @(negedge hclk);
      end
      // Returns one edge after the update, so stimulus that follows stays on rising edges
      repeat (2) @(posedge hclk);
   endtask

   task automatic pollb(input int b, input logic val, input int lim);
      int n;
      n = 0;
      while (work_bits[b] !== val && n < lim) begin
         @(negedge hclk);
         n = n + 1;
      end
      chk(work_bits[b], val);
      @(posedge hclk);
   endtask

   // Whole run is near 2500 cycles; eight times that is clearly a hang
   initial begin
      #200000;
      num_errors = num_errors + 1;
      conclude();
   end

   initial begin
      rows = '{'{3'd0, 4'h0, 1'b1, 4'hf, 1'b0}, '{3'd5, 4'h0, 1'b0, 4'hf, 1'b0},
               '{3'd1, 4'h0, 1'b0, 4'h3, 1'b1}, '{3'd1, 4'h0, 1'b0, 4'hc, 1'b1},
               '{3'd1, 4'h0, 1'b0, 4'h5, 1'b0}, '{3'd2, 4'h0, 1'b0, 4'h5, 1'b0},
               '{3'd2, 4'h0, 1'b0, 4'h9, 1'b1}, '{3'd3, 4'h0, 1'b0, 4'h0, 1'b0},
               '{3'd3, 4'h0, 1'b0, 4'h8, 1'b1}, '{3'd4, 4'h0, 1'b0, 4'hf, 1'b1},
               '{3'd4, 4'h0, 1'b0, 4'h7, 1'b0}, '{3'd4, 4'h8, 1'b0, 4'h7, 1'b1},
               '{3'd3, 4'h0, 1'b1, 4'h0, 1'b1}};
      ra = '{8'h14, 8'h18, 8'h78, 8'h84, 8'h8c};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 0; i < 13; i++) begin
         cfg(0, 32'h0605_0403, {20'h0, rows[i].inv, 3'h0, rows[i].oinv, 1'b0, rows[i].op});
         src_v <= {57'h0, rows[i].ev, 3'h0};
         evw(2);
         chk(work_bits[0], rows[i].exp);
      end
      for (c = 0; c < 41; c++) begin
         cfg(0, 32'(c) << (8 * (c % 4)), 32'h3);
         src_v <= ~(64'h1 << c) & 64'h0001_ffff_ffff_ffff;
         evw(2);
         chk(work_bits[0], c == 1);
         src_v <= 64'h1 << c;
         evw(2);
         chk(work_bits[0], c == 1 || (c > 2 && c != 35));
      end
      // Reset again in mid-run; code 2 must be configured before the first evaluation
      hresetn <= 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      cfg(0, 32'h2, 32'h3);
      evw(1);
      chk(work_bits, 8'h01);
      evw(1);
      chk(work_bits, 8'h00);
      for (i = 0; i < 5; i++) begin
         bus(1'b0, ra[i], 32'h0);
         chk(rd, 32'h0);
      end
      bus(1'b1, 8'h80, 32'hff);
      bus(1'b0, 8'h80, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 8'h70, 32'hffff_ffff);
      bus(1'b0, 8'h70, 32'h0);
      chk(rd, 32'h3f3f_3f3f);
      bus(1'b1, 8'h78, 32'h3fff_3fff);
      bus(1'b0, 8'h78, 32'h0);
      chk(rd, 32'h270f_270f);
      src_v <= {32'h0000_011d, 32'h0};
      bus(1'b0, 8'h88, 32'h0);
      chk(rd, 32'h0000_0115);
      cfg(0, 32'd10, 32'h3);
      src_v <= 64'h1 << 49;
      evw(2);
      chk(work_bits[0], 1'b1);
      for (i = 0; i < 3; i++) begin
         cfg(0, (i == 0) ? 32'd11 : 32'd12, 32'h3);
         bus(1'b1, 8'h84, 32'h1 << i);
         src_v <= 64'h1800;
         evw(2);
         chk(work_bits[0], 1'b0);
      end
      bus(1'b1, 8'h84, 32'h0);
      cfg(0, 32'h0, 32'h0);
      cfg(1, 32'd41 << 24, 32'h3);
      evw(2);
      cfg(0, 32'd1, 32'h3);
      evw(1);
      chk(work_bits, 8'h01);
      evw(1);
      chk(work_bits, 8'h03);
      cfg(2, 32'd3, 32'h3);
      bus(1'b1, 8'h28, {2'h0, 14'd2, 2'h0, 14'd3});
      src_v <= 64'h0;
      evw(2);
      src_v <= 64'h8;
      repeat (30) @(negedge hclk);
      chk(work_bits[2], 1'b0);
      pollb(2, 1'b1, 120);
      src_v <= 64'h0;
      repeat (15) @(negedge hclk);
      chk(work_bits[2], 1'b1);
      pollb(2, 1'b0, 100);
      bus(1'b1, 8'h24, 32'h1003);
      src_v <= 64'h8;
      repeat (110) @(negedge hclk);
      chk(work_bits[2], 1'b0);
      pollb(2, 1'b1, 300);
      conclude();
   end
endmodule
